/* design/vcr_pkg.sv */
package vcr_pkg;

   // ==========================================================
   // Register subaddresses
   // ==========================================================
   localparam logic [7:0] SYNC_PIN_FUNCTION_ADDR = 8'h10;
   localparam logic [7:0] COLOUR_STANDARD_SELECT_ADDR = 8'h20;
   localparam logic [7:0] VIDEO_INPUT_SELECT_ADDR = 8'h21;
   localparam logic [7:0] GENERAL_PIN_DATA_DIRECTION_ADDR = 8'h34;
   localparam logic [7:0] HARDWARE_IDENTIFICATION_ADDR = 8'h9F;

   // ==========================================================
   // Reset values (every bus register clears to zero)
   // ==========================================================
   localparam logic [7:0] SYNC_PIN_FUNCTION_RESET = 8'h00;
   localparam logic [11:0] COLOUR_STANDARD_SELECT_RESET = 12'h000;
   localparam logic [11:0] VIDEO_INPUT_SELECT_RESET = 12'h000;
   localparam logic [6:0] GENERAL_PIN_RESET = 7'h00;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SYNC_FN_LSB = 6;
   localparam int GP_DIR_LSB = 8;
   localparam int STD_MODIFIER_BIT = 3;
   localparam int STD_COMB_BIT = 5;
   localparam int STD_SEPARATE_LC_BIT = 6;
   localparam int STD_NO_HLOOP_BIT = 7;
   localparam int STD_NO_VERT_BIT = 8;
   localparam int STD_NO_COLOUR_BIT = 9;
   localparam int STD_COMB_ONLY_BIT = 10;
   localparam int STD_DONE_BIT = 11;
   // Bit 4 is reserved and never stored
   localparam logic [11:0] STD_WRITE_MASK = 12'hFEF;

   // ==========================================================
   // Sync pin functions and colour standards
   // ==========================================================
   typedef enum logic [1:0] {
      VCR_SYNC_COMPOSITE = 2'b00,
      VCR_SYNC_FIELD = 2'b01,
      VCR_SYNC_HSYNC = 2'b10,
      VCR_SYNC_HDRIVE = 2'b11
   } vcr_sync_fn_t;

   typedef enum logic [2:0] {
      VCR_STD_PAL_BGHI = 3'h0,
      VCR_STD_NTSC_M = 3'h1,
      VCR_STD_SECAM = 3'h2,
      VCR_STD_NTSC_443 = 3'h3,
      VCR_STD_PAL_M = 3'h4,
      VCR_STD_PAL_N = 3'h5,
      VCR_STD_PAL_60 = 3'h6,
      VCR_STD_COMB_FILTERED_NTSC = 3'h7
   } vcr_std_t;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int MCLK_HZ = 10_000_000;
   localparam int HDRIVE_HZ = 1_000_000;
   // Half period of the drive clock in mclk cycles
   localparam int HDRIVE_HALF_CYCLES = MCLK_HZ / (2 * HDRIVE_HZ);
   localparam int MCLK_PERIOD_NS = 100;
   localparam int SETUP_PHASE_NS = 10_000;
   localparam int SETUP_PHASE_CYCLES = SETUP_PHASE_NS / MCLK_PERIOD_NS;

   // ==========================================================
   // Serial bus
   // ==========================================================
   localparam logic [6:0] DEVICE_ADDRESS = 7'h58;

endpackage

/* design/vcr_i2c_slave.sv */
// ==========================================================
// Serial slave: subaddress, then one or two data bytes
// ==========================================================
module vcr_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = vcr_pkg::DEVICE_ADDRESS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [7:0] reg_addr,
   input wire logic reg_two_bytes,
   input wire logic [15:0] rd_data,
   output logic wr_strobe,
   output logic [15:0] wr_data
);

   typedef enum logic [3:0] {
      VCR_I_IDLE = 4'h0,
      VCR_I_DEV = 4'h1,
      VCR_I_ACK_DEV = 4'h2,
      VCR_I_SUB = 4'h3,
      VCR_I_ACK_SUB = 4'h4,
      VCR_I_WDATA = 4'h5,
      VCR_I_ACK_W = 4'h6,
      VCR_I_RDATA = 4'h7,
      VCR_I_ACK_R = 4'h8
   } vcr_i2c_state_t;

   typedef struct packed {
      vcr_i2c_state_t state;
      logic scl_q;
      logic sda_q;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [7:0] rd_low;
      logic rw;
      logic byte_idx;
      logic acked;
      logic drv;
      logic [7:0] sub;
      logic strobe;
      logic [15:0] wdata;
   } vcr_i2c_t;

   vcr_i2c_t s_reg, s_next;
   logic rise, fall, start, stop;

   // Bus events against the last samples
   assign rise = scl_in & ~s_reg.scl_q;
   assign fall = ~scl_in & s_reg.scl_q;
   assign start = scl_in & s_reg.scl_q & s_reg.sda_q & ~sda_in;
   assign stop = scl_in & s_reg.scl_q & ~s_reg.sda_q & sda_in;

   // Shift on SCL rise, change drive on SCL fall
   always_comb begin
      s_next = s_reg;
      s_next.scl_q = scl_in;
      s_next.sda_q = sda_in;
      s_next.strobe = 1'b0;
      if (rise && s_reg.state != VCR_I_ACK_R) begin
         s_next.shreg = {s_reg.shreg[6:0], sda_in};
         s_next.cnt = s_reg.cnt + 4'h1;
      end
      case (s_reg.state)
         VCR_I_IDLE: ;
         VCR_I_DEV: begin
            if (fall && s_reg.cnt == 4'h8) begin
               s_next.rw = s_reg.shreg[0];
               if (s_reg.shreg[7:1] == DEV_ADDR) begin
                  s_next.drv = 1'b1;
                  s_next.state = VCR_I_ACK_DEV;
               end else begin
                  s_next.state = VCR_I_IDLE;
               end
            end
         end
         VCR_I_ACK_DEV: begin
            if (fall) begin
               s_next.cnt = 4'h0;
               if (s_reg.rw) begin
                  // Snapshot keeps both bytes coherent
                  s_next.tx = reg_two_bytes ? rd_data[15:8] : rd_data[7:0];
                  s_next.rd_low = reg_two_bytes ? rd_data[7:0] : 8'h00;
                  s_next.byte_idx = 1'b0;
                  s_next.drv = reg_two_bytes ? ~rd_data[15] : ~rd_data[7];
                  s_next.state = VCR_I_RDATA;
               end else begin
                  s_next.drv = 1'b0;
                  s_next.state = VCR_I_SUB;
               end
            end
         end
         VCR_I_SUB: begin
            if (fall && s_reg.cnt == 4'h8) begin
               s_next.sub = s_reg.shreg;
               s_next.byte_idx = 1'b0;
               s_next.drv = 1'b1;
               s_next.state = VCR_I_ACK_SUB;
            end
         end
         VCR_I_ACK_SUB, VCR_I_ACK_W: begin
            if (fall) begin
               s_next.drv = 1'b0;
               s_next.cnt = 4'h0;
               s_next.state = VCR_I_WDATA;
            end
         end
         VCR_I_WDATA: begin
            if (fall && s_reg.cnt == 4'h8) begin
               s_next.drv = 1'b1;
               s_next.state = VCR_I_ACK_W;
               if (reg_two_bytes && !s_reg.byte_idx) begin
                  s_next.byte_idx = 1'b1;
                  s_next.wdata = {s_reg.shreg, 8'h00};
               end else begin
                  s_next.byte_idx = 1'b0;
                  s_next.strobe = 1'b1;
                  s_next.wdata = reg_two_bytes ?
                     {s_reg.wdata[15:8], s_reg.shreg} : {8'h00, s_reg.shreg};
               end
            end
         end
         VCR_I_RDATA: begin
            if (fall) begin
               if (s_reg.cnt == 4'h8) begin
                  s_next.drv = 1'b0;
                  s_next.state = VCR_I_ACK_R;
               end else begin
                  s_next.tx = {s_reg.tx[6:0], 1'b0};
                  s_next.drv = ~s_reg.tx[6];
               end
            end
         end
         VCR_I_ACK_R: begin
            if (rise) begin
               s_next.acked = ~sda_in;
            end
            if (fall) begin
               s_next.cnt = 4'h0;
               if (s_reg.acked) begin
                  // Zeros past the last byte
                  s_next.tx = s_reg.byte_idx ? 8'h00 : s_reg.rd_low;
                  s_next.drv = s_reg.byte_idx ? 1'b1 : ~s_reg.rd_low[7];
                  s_next.rd_low = 8'h00;
                  s_next.byte_idx = 1'b1;
                  s_next.state = VCR_I_RDATA;
               end else begin
                  s_next.state = VCR_I_IDLE;
               end
            end
         end
         default: s_next.state = VCR_I_IDLE;
      endcase
      if (start) begin
         s_next.state = VCR_I_DEV;
         s_next.cnt = 4'h0;
         s_next.drv = 1'b0;
      end else if (stop) begin
         s_next.state = VCR_I_IDLE;
         s_next.drv = 1'b0;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.scl_q <= 1'b1;
         s_reg.sda_q <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sda_out = 1'b0; // Open drain: only ever pulls low
   assign sda_oe = s_reg.drv;
   assign reg_addr = s_reg.sub;
   assign wr_strobe = s_reg.strobe;
   assign wr_data = s_reg.wdata;

endmodule // vcr_i2c_slave

/* design/vcr_video_control_registers.sv */
// Behaviour
// - Sync pin bits 7:6 pick composite sync, field, hsync or 1 MHz drive.
// - Pin data bits drive output pins; reads return the pin levels.
// - Bits 14:8 set pin directions, one means output; 7 and 15 reserved.
// - Read-only identification word: revision low byte, product high byte.
// - Standard field bits 2:0 choose one of eight colour standards.
// - Modifier bit alters the chosen standard to its variant.
// - Comb enable bit switches the two-line comb filter on or off.
// - Separate luma/chroma mode forces the comb filter off.
// - Bits 7, 8, 9 skip horizontal, vertical, colour setup steps.
// - Comb-only bit limits initialisation to the comb filter setup.
// - Host writes completion bit as zero; device sets it when finished.
// - Writing the input selection register reruns standard initialisation.
// - All bus registers clear to zero on reset.
module vcr_video_control_registers #(
   parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
   parameter logic [7:0] PRODUCT_CODE = 8'h5A, // Arbitrary value
   parameter int SETUP_CYCLES = vcr_pkg::SETUP_PHASE_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic composite_sync_in,
   input wire logic field_in,
   input wire logic hsync_in,
   output logic sync_output_pin,
   input wire logic [6:0] general_pin_in,
   output logic [6:0] general_pin_out,
   output logic [6:0] general_pin_oe,
   output logic [11:0] video_input_select,
   output logic [2:0] colour_standard,
   output logic standard_modifier,
   output logic monochrome,
   output logic comb_filter_on,
   output logic separate_luma_chroma_mode,
   output logic [3:0] setup_active,
   output logic init_busy
);

   typedef enum logic [1:0] {
      VCR_INIT_IDLE = 2'b00,
      VCR_INIT_RUN = 2'b01
   } vcr_init_state_t;

   typedef struct packed {
      logic [1:0] sync_fn;
      logic [6:0] gp_data;
      logic [6:0] gp_dir;
      logic [11:0] std;
      logic [11:0] insel;
      vcr_init_state_t init_state;
      logic [3:0] phase_mask;
      logic [1:0] phase;
      logic [15:0] phase_cnt;
      logic [3:0] hdrive_cnt;
      logic hdrive_clk;
      logic sync_out;
      logic [6:0] pin_out;
      logic [6:0] pin_oe;
   } vcr_regs_t;

   vcr_regs_t r_reg, r_next;
   logic [7:0] reg_addr;
   logic [15:0] rd_data;
   logic [15:0] wr_data;
   logic wr_strobe;
   logic reg_two_bytes;
   logic [6:0] pin_values;
   logic init_start;
   logic init_finish;
   logic [3:0] start_mask;

   // ==========================================================
   // Serial bus slave
   // ==========================================================
   vcr_i2c_slave u_slave (
      .mclk(mclk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .reg_addr(reg_addr),
      .reg_two_bytes(reg_two_bytes),
      .rd_data(rd_data),
      .wr_strobe(wr_strobe),
      .wr_data(wr_data)
   );

   // ==========================================================
   // Read side
   // ==========================================================
   // Outputs read own data, inputs the pin
   assign pin_values = (r_reg.gp_dir & r_reg.gp_data) |
                       (~r_reg.gp_dir & general_pin_in);

   // Read mux; unmapped reads zero
   always_comb begin
      rd_data = 16'h0000;
      reg_two_bytes = 1'b1;
      case (reg_addr)
         vcr_pkg::SYNC_PIN_FUNCTION_ADDR: begin
            reg_two_bytes = 1'b0;
            rd_data = {8'h00, r_reg.sync_fn, 6'h00};
         end
         vcr_pkg::COLOUR_STANDARD_SELECT_ADDR:
            rd_data = {4'h0, r_reg.std};
         vcr_pkg::VIDEO_INPUT_SELECT_ADDR:
            rd_data = {4'h0, r_reg.insel};
         vcr_pkg::GENERAL_PIN_DATA_DIRECTION_ADDR:
            rd_data = {1'b0, r_reg.gp_dir, 1'b0, pin_values};
         vcr_pkg::HARDWARE_IDENTIFICATION_ADDR:
            rd_data = {PRODUCT_CODE, REVISION_CODE};
         default: rd_data = 16'h0000;
      endcase
   end

   // ==========================================================
   // Initialisation trigger
   // ==========================================================
   // Either write restarts it, even mid-run
   assign init_start = wr_strobe &&
      (reg_addr == vcr_pkg::COLOUR_STANDARD_SELECT_ADDR ||
       reg_addr == vcr_pkg::VIDEO_INPUT_SELECT_ADDR);

   // Phases: 0 horizontal, 1 vertical, 2 colour, 3 comb filter
   always_comb begin
      logic [11:0] nstd;
      nstd = (reg_addr == vcr_pkg::COLOUR_STANDARD_SELECT_ADDR) ?
             (wr_data[11:0] & vcr_pkg::STD_WRITE_MASK) : r_reg.std;
      if (nstd[vcr_pkg::STD_COMB_ONLY_BIT]) begin
         start_mask = 4'b1000;
      end else begin
         start_mask = {1'b1, ~nstd[vcr_pkg::STD_NO_COLOUR_BIT],
                       ~nstd[vcr_pkg::STD_NO_VERT_BIT],
                       ~nstd[vcr_pkg::STD_NO_HLOOP_BIT]};
      end
   end

   assign init_finish = (r_reg.init_state == VCR_INIT_RUN) &&
      (r_reg.phase == 2'd3) &&
      (!r_reg.phase_mask[3] ||
       r_reg.phase_cnt == 16'(SETUP_CYCLES - 1));

   // ==========================================================
   // Register and sequencer update
   // ==========================================================
   always_comb begin
      r_next = r_reg;
      // Register writes
      if (wr_strobe) begin
         case (reg_addr)
            vcr_pkg::SYNC_PIN_FUNCTION_ADDR:
               r_next.sync_fn = wr_data[7:vcr_pkg::SYNC_FN_LSB];
            vcr_pkg::COLOUR_STANDARD_SELECT_ADDR:
               r_next.std = wr_data[11:0] & vcr_pkg::STD_WRITE_MASK;
            vcr_pkg::VIDEO_INPUT_SELECT_ADDR:
               r_next.insel = wr_data[11:0];
            vcr_pkg::GENERAL_PIN_DATA_DIRECTION_ADDR: begin
               r_next.gp_data = wr_data[6:0];
               r_next.gp_dir = wr_data[14:vcr_pkg::GP_DIR_LSB];
            end
            default: ;
         endcase
      end
      // Sequencer; a skipped phase passes in one cycle
      case (r_reg.init_state)
         VCR_INIT_IDLE: ;
         VCR_INIT_RUN: begin
            if (!r_reg.phase_mask[r_reg.phase] ||
                r_reg.phase_cnt == 16'(SETUP_CYCLES - 1)) begin
               r_next.phase_cnt = 16'h0000;
               r_next.phase = r_reg.phase + 2'd1;
               if (r_reg.phase == 2'd3) begin
                  r_next.init_state = VCR_INIT_IDLE;
               end
            end else begin
               r_next.phase_cnt = r_reg.phase_cnt + 16'h0001;
            end
         end
         default: r_next.init_state = VCR_INIT_IDLE;
      endcase
      // A host write wins over the device set
      if (init_finish && !init_start) begin
         r_next.std[vcr_pkg::STD_DONE_BIT] = 1'b1;
      end
      if (init_start) begin
         r_next.init_state = VCR_INIT_RUN;
         r_next.phase_mask = start_mask;
         r_next.phase = 2'd0;
         r_next.phase_cnt = 16'h0000;
      end
      // Free-running 1 MHz drive divider
      if (r_reg.hdrive_cnt == 4'(vcr_pkg::HDRIVE_HALF_CYCLES - 1)) begin
         r_next.hdrive_cnt = 4'h0;
         r_next.hdrive_clk = ~r_reg.hdrive_clk;
      end else begin
         r_next.hdrive_cnt = r_reg.hdrive_cnt + 4'h1;
      end
      // Registered so the pin stays glitch free
      case (vcr_pkg::vcr_sync_fn_t'(r_reg.sync_fn))
         vcr_pkg::VCR_SYNC_COMPOSITE: r_next.sync_out = composite_sync_in;
         vcr_pkg::VCR_SYNC_FIELD: r_next.sync_out = field_in;
         vcr_pkg::VCR_SYNC_HSYNC: r_next.sync_out = hsync_in;
         vcr_pkg::VCR_SYNC_HDRIVE: r_next.sync_out = r_reg.hdrive_clk;
         default: r_next.sync_out = composite_sync_in;
      endcase
      r_next.pin_out = r_next.gp_data;
      r_next.pin_oe = r_next.gp_dir;
   end

   // State register, cleared to zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign sync_output_pin = r_reg.sync_out;
   assign general_pin_out = r_reg.pin_out;
   assign general_pin_oe = r_reg.pin_oe;
   assign video_input_select = r_reg.insel;
   assign colour_standard = r_reg.std[2:0];
   assign standard_modifier = r_reg.std[vcr_pkg::STD_MODIFIER_BIT];
   // Modified SECAM, comb NTSC go monochrome
   assign monochrome = r_reg.std[vcr_pkg::STD_MODIFIER_BIT] &&
      (r_reg.std[2:0] == vcr_pkg::VCR_STD_SECAM ||
       r_reg.std[2:0] == vcr_pkg::VCR_STD_COMB_FILTERED_NTSC);
   assign separate_luma_chroma_mode = r_reg.std[vcr_pkg::STD_SEPARATE_LC_BIT];
   assign comb_filter_on = r_reg.std[vcr_pkg::STD_COMB_BIT] &&
      !r_reg.std[vcr_pkg::STD_SEPARATE_LC_BIT];
   assign init_busy = (r_reg.init_state == VCR_INIT_RUN);
   // One level per setup phase while it runs
   assign setup_active = (r_reg.init_state == VCR_INIT_RUN) ?
      (r_reg.phase_mask & (4'b0001 << r_reg.phase)) : 4'h0;

endmodule // vcr_video_control_registers

/* tb/vcr_video_control_registers_assertions.sv */
// ==========================================================
// Port checks
// ==========================================================
module vcr_video_control_registers_checker #(
   parameter int SETUP_CYCLES = 4
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic [6:0] general_pin_oe,
   input wire logic [11:0] video_input_select,
   input wire logic [2:0] colour_standard,
   input wire logic standard_modifier,
   input wire logic monochrome,
   input wire logic comb_filter_on,
   input wire logic separate_luma_chroma_mode,
   input wire logic [3:0] setup_active,
   input wire logic init_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // Cycles in the current h-loop phase
   int run0;
   always_ff @(posedge mclk)
      run0 <= (reset || !setup_active[0]) ? 0 : run0 + 1;

   // ==========================================================
   // Assertions
   // ==========================================================
   chk_reset_clear: assert property ($fell(reset) |->
      general_pin_oe == 7'h00 && init_busy == 1'b0 && setup_active == 4'h0
      && colour_standard == 3'h0 && video_input_select == 12'h000)
      else $error("reset not cleared");
   chk_mono_map: assert property (monochrome == (standard_modifier &&
      (colour_standard == 3'h2 || colour_standard == 3'h7)))
      else $error("monochrome wrong");
   chk_comb_gate: assert property (comb_filter_on |->
      !separate_luma_chroma_mode)
      else $error("comb on in separate mode");
   chk_phase_onehot: assert property ($onehot0(setup_active))
      else $error("phases overlap");
   chk_busy_phase: assert property (|setup_active |-> init_busy)
      else $error("phase while idle");
   chk_phase_len: assert property ($fell(setup_active[0]) |->
      (run0 == SETUP_CYCLES || run0 == 1))
      else $error("h-loop length");
   chk_pins_scl_low: assert property ($changed(general_pin_oe) |->
      !scl_in)
      else $error("direction change off write");
   chk_busy_start: assert property ($rose(init_busy) |-> !scl_in)
      else $error("init start off write");

   cover property ($rose(init_busy));
   cover property (comb_filter_on);
   cover property (monochrome);
endmodule // vcr_video_control_registers_checker

bind vcr_video_control_registers vcr_video_control_registers_checker #(
   .SETUP_CYCLES(SETUP_CYCLES)
) i_chk (
   .mclk(mclk),
   .reset(reset),
   .scl_in(scl_in),
   .general_pin_oe(general_pin_oe),
   .video_input_select(video_input_select),
   .colour_standard(colour_standard),
   .standard_modifier(standard_modifier),
   .monochrome(monochrome),
   .comb_filter_on(comb_filter_on),
   .separate_luma_chroma_mode(separate_luma_chroma_mode),
   .setup_active(setup_active),
   .init_busy(init_busy)
);

/* tb/vcr_host_model.sv */
// ==========================================================
// Serial bus master standing in for the host controller
// ==========================================================
module vcr_host_model (
   input wire logic mclk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus: both lines released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // One bit; SDA moves while SCL is low
   task automatic bit_io(input logic b, output logic r);
      @(posedge mclk) sda_drv <= b;
      repeat (2) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      r = sda_wire;
      scl <= 1'b0;
   endtask

   // Start is (1, 0), stop (0, 1); extra wait lets the ack go first
   task automatic cond(input logic a, input logic b);
      @(posedge mclk) sda_drv <= a;
      repeat (3) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      sda_drv <= b;
      repeat (2) @(posedge mclk);
      if (!b) scl <= 1'b0;
   endtask

   // Eight bits MSB first, ninth bit is mack
   task automatic xfer(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(mack, r);
      ack = ~r;
   endtask
endmodule // vcr_host_model

/* tb/vcr_video_control_registers_bench.sv */
module vcr_video_control_registers_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] REV = 8'h3C; // Arbitrary value
   localparam logic [7:0] PROD = 8'hC3; // Arbitrary value
   localparam logic [15:0] SETUP = 16'h0004;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic scl, sda_drv, sda_out, sda_oe, sda_wire, sync_pin;
   logic csync = 1'b0, field = 1'b0, hsync = 1'b0;
   logic [6:0] pin_in = 7'h7A, pin_out, pin_oe;
   logic [11:0] vsel;
   logic [2:0] std;
   logic modif, mono, comb, slc, busy;
   logic [3:0] phase;
   logic [15:0] init_vals [3] = '{16'h0000, 16'h0380, 16'h0410};
   int mismatches = 0, compares = 0, n;
   int cnt [4];
   logic p;

   always #50 mclk = ~mclk;
   // Open-drain data line with pull-up
   assign sda_wire = sda_drv & ~sda_oe;
   // Cycles spent in each setup phase
   always @(posedge mclk)
      for (int k = 0; k < 4; k++)
         if (phase[k] === 1'b1) cnt[k]++;

   vcr_host_model i_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl),
      .sda_drv(sda_drv));
   vcr_video_control_registers #(.REVISION_CODE(REV), .PRODUCT_CODE(PROD),
      .SETUP_CYCLES(4)) i_dut (.mclk(mclk), .reset(reset), .scl_in(scl),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .composite_sync_in(csync), .field_in(field), .hsync_in(hsync),
      .sync_output_pin(sync_pin), .general_pin_in(pin_in),
      .general_pin_out(pin_out), .general_pin_oe(pin_oe),
      .video_input_select(vsel), .colour_standard(std),
      .standard_modifier(modif), .monochrome(mono), .comb_filter_on(comb),
      .separate_luma_chroma_mode(slc), .setup_active(phase),
      .init_busy(busy));

   // ==========================================================
   // Bus access and comparison
   // ==========================================================
   task automatic check(input string w, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      logic [7:0] q;
      logic k;
      i_host.cond(1'b1, 1'b0);
      i_host.xfer({vcr_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, q, k);
      check("address ack", 16'h0001, {15'h0000, k});
      i_host.xfer(a, 1'b1, q, k);
      if (a != 8'h10) i_host.xfer(d[15:8], 1'b1, q, k);
      i_host.xfer(d[7:0], 1'b1, q, k);
      i_host.cond(1'b0, 1'b1);
   endtask

   // Read a register; 0x10 lands in the low byte
   task automatic rd_check(input logic [7:0] a, input string w,
                           input logic [15:0] e);
      logic [7:0] q;
      logic [15:0] v = 16'h0000;
      logic k;
      i_host.cond(1'b1, 1'b0);
      i_host.xfer({vcr_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, q, k);
      i_host.xfer(a, 1'b1, q, k);
      i_host.cond(1'b1, 1'b0);
      i_host.xfer({vcr_pkg::DEVICE_ADDRESS, 1'b1}, 1'b1, q, k);
      if (a != 8'h10) i_host.xfer(8'hFF, 1'b0, v[15:8], k);
      i_host.xfer(8'hFF, 1'b1, v[7:0], k);
      i_host.cond(1'b0, 1'b1);
      check(w, e, v);
   endtask

   // Bounded wait for init to end
   task automatic wait_idle();
      for (int t = 0; busy !== 1'b0; t++) begin
         if (t == 500) begin
            mismatches++;
            end_of_test();
         end
         @(posedge mclk);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd_check(8'h10, "sync reset", 16'h0000);
      rd_check(8'h20, "standard reset", 16'h0000);
      rd_check(8'h34, "pin reset", 16'h007A);
      rd_check(8'h9F, "ident", {PROD, REV});
      reg_write(8'h9F, 16'h1234);
      rd_check(8'h9F, "ident after write", {PROD, REV});
      rd_check(8'h55, "unmapped", 16'h0000);
      $display("test ident done");
      for (int c = 0; c < 4; c++) begin
         reg_write(8'h10, {8'h00, c[1:0], 6'h00});
         rd_check(8'h10, "sync function", {8'h00, c[1:0], 6'h00});
         for (int lv = 0; lv < 2 && c < 3; lv++) begin
            @(posedge mclk);
            {hsync, field, csync} <= lv[0] ? 3'(1 << c) : ~3'(1 << c);
            repeat (3) @(posedge mclk);
            check("sync pin", lv[15:0], {15'h0000, sync_pin});
         end
      end
      // 1 MHz drive clock: a toggle every 5 cycles
      n = 0;
      @(posedge mclk);
      p = sync_pin;
      repeat (40) begin
         @(posedge mclk);
         if (sync_pin !== p) n++;
         p = sync_pin;
      end
      check("drive toggles", 16'h0008, n[15:0]);
      $display("test sync done");
      reg_write(8'h34, 16'hFF85);
      check("pin dirs", 16'h007F, {9'h000, pin_oe});
      check("pin data", 16'h0005, {9'h000, pin_out});
      rd_check(8'h34, "pin reserved", 16'h7F05);
      reg_write(8'h34, 16'h0305);
      rd_check(8'h34, "pin mix", 16'h0379);
      $display("test pin port done");
      for (int s = 0; s < 8; s++) begin
         reg_write(8'h20, {12'h000, 1'b1, s[2:0]});
         check("standard", s[15:0], {13'h0000, std});
         check("mono", {15'h0000, s == 2 || s == 7}, {15'h0000, mono});
      end
      reg_write(8'h20, 16'h0020);
      check("comb on", 16'h0001, {15'h0000, comb});
      reg_write(8'h20, 16'h0060);
      check("comb forced off", 16'h0000, {15'h0000, comb});
      check("separate mode", 16'h0001, {15'h0000, slc});
      $display("test standards done");
      foreach (init_vals[i]) begin
         wait_idle();
         @(negedge mclk);
         cnt = '{default: 0};
         reg_write(8'h20, init_vals[i]);
         wait_idle();
         for (int k = 0; k < 3; k++)
            check("phase", (init_vals[i][7 + k] || init_vals[i][10]) ?
               16'h0000 : SETUP, cnt[k][15:0]);
         check("comb phase", SETUP, cnt[3][15:0]);
         rd_check(8'h20, "done", init_vals[i] & 16'h0FEF | 16'h0800);
      end
      @(negedge mclk);
      cnt = '{default: 0};
      reg_write(8'h21, 16'h0ABC);
      check("input select", 16'h0ABC, {4'h0, vsel});
      wait_idle();
      check("rerun", SETUP, cnt[3][15:0]);
      $display("test init done");
      end_of_test();
   end
endmodule // vcr_video_control_registers_bench
